// >>> mmc_pkg.sv
// Constants, types and pin bundles for the module management control block.
// Assumes a 250 MHz hclk, an AHB-Lite master on the local side and a 2-wire
// management host on the module pins.
package mmc_pkg;

   // Clock and timing
   localparam int          CLK_PERIOD_NS = 4;
   localparam int          RST_MIN_NS    = 2000;
   localparam int          RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          INIT_MS       = 2000;
   localparam int unsigned INIT_CYC      = INIT_MS * (1000000 / CLK_PERIOD_NS);

   // 2-wire device address, seven bits (A0h as an 8-bit write address)
   localparam logic [6:0] DEV_ADDR = 7'h50;

   // Management memory layout
   localparam int LOWER_BYTES   = 128;
   localparam int UPPER_PAGES   = 4;
   localparam int MEM_BYTES     = LOWER_BYTES * (UPPER_PAGES + 1);
   localparam int STATUS_BYTE   = 2;
   localparam int DNR_BIT       = 0;
   localparam int FLAG_FIRST    = 3;
   localparam int FLAG_LAST     = 21;
   localparam int CTRL_FIRST    = 86;
   localparam int PAGE_SEL_BYTE = 127;
   localparam logic [7:0] MEM_RESET = 8'h00;

   // Local register map (byte addresses)
   localparam logic [7:0] REG_STATUS     = 8'h00;
   localparam logic [7:0] REG_FLAG_EVENT = 8'h04;
   localparam logic [7:0] REG_MEM_ADDR   = 8'h08;
   localparam logic [7:0] REG_MEM_DATA   = 8'h0c;

   // Status register fields
   localparam int ST_SELECTED = 0;
   localparam int ST_INIT     = 1;
   localparam int ST_IRQ      = 2;
   localparam int ST_LOWPOWER = 3;
   localparam int ST_DONE     = 4;

   // Flag event register fields
   localparam int FE_BITS_LSB = 0;
   localparam int FE_BYTE_LSB = 8;

   // Module pins as seen after synchronising
   typedef struct packed {
      logic sel_n;
      logic rst_n;
      logic lp;
      logic scl;
      logic sda;
   } mmc_pins_s;

   // Pin levels held before the first sample: deselected, not in reset, bus idle
   localparam mmc_pins_s PINS_RESET = '{sel_n: 1'b1, rst_n: 1'b1, lp: 1'b0,
                                        scl: 1'b1, sda: 1'b1};

   // AHB address phase held for its data phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } mmc_ahb_s;

   typedef enum logic [2:0] {
      I2C_IDLE,
      I2C_RX,
      I2C_ACK_OUT,
      I2C_TX,
      I2C_ACK_IN
   } mmc_i2c_e;

endpackage

// >>> mmc_mgmt_pins.sv
// Management and low-speed control pins of a four-lane pluggable module.
// Holds the 2-wire slave, select gating, reset pulse timing, low-power,
// presence, open-drain interrupt and the paged management memory.
// Assumes all pin inputs are asynchronous to hclk and the bus pull-ups are
// on the host board.
`timescale 1ns/1ns
module mmc_mgmt_pins #(
   parameter int unsigned INIT_CYCLES = mmc_pkg::INIT_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Module pins
   input  wire logic        module_select_n,
   input  wire logic        module_reset_n,
   input  wire logic        low_power_request,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   output logic             interrupt_out_n,
   output logic             interrupt_oe_n,
   output logic             module_present_n,
   output logic             low_power_state
);

   // Synchroniser stages and previous sample for edge finding
   mmc_pkg::mmc_pins_s pin_meta;           // First stage, read by second only
   mmc_pkg::mmc_pins_s pin;                // Second stage, safe to use
   logic               scl_prev;           // Last clock line sample
   logic               sda_prev;           // Last data line sample

   // 2-wire slave state
   mmc_pkg::mmc_i2c_e  state, next_state;
   logic [7:0]         shreg, next_shreg;  // Shift register
   logic [3:0]         bit_cnt, next_bit_cnt;
   logic               first, next_first;  // Next byte is the address byte
   logic               got_ptr, next_got_ptr;
   logic               rd_mode, next_rd_mode;
   logic               ack_ok, next_ack_ok;
   logic               drive_low, next_drive_low;
   logic [7:0]         ptr, next_ptr;      // Byte offset within the window
   logic               i2c_wr;             // One-cycle write of a byte
   logic               i2c_rd;             // One-cycle read of a byte
   logic [9:0]         i2c_idx;            // Memory index for either pulse

   // Reset pin timing
   logic [9:0]         low_cnt, next_low_cnt;
   logic               init_active, next_init_active;
   logic [31:0]        init_cnt, next_init_cnt;
   logic               done_flag, next_done_flag;
   logic               soft_reset;         // Valid reset held low
   logic               done_set;           // Init interval just ended

   // Memory and interrupt
   logic [7:0]         mem [mmc_pkg::MEM_BYTES];
   logic [7:0]         next_mem [mmc_pkg::MEM_BYTES];
   logic               irq, next_irq;
   logic               flag_any;
   logic [7:0]         rd_byte;            // Byte the 2-wire slave returns

   // AHB slave
   mmc_pkg::mmc_ahb_s  aph, next_aph;
   logic               rd_pend, next_rd_pend;
   logic [31:0]        next_hrdata;
   logic [9:0]         mem_idx, next_mem_idx;
   logic               bus_wr_mem;
   logic               bus_flag_ev;
   logic [7:0]         selected_data;

   // Window index: lower page direct, upper half through the page select
   function automatic logic [9:0] win_index(input logic [7:0] p, input logic [1:0] page);
      if (p[7]) begin
         win_index = 10'(mmc_pkg::LOWER_BYTES) + {page, p[6:0]};
      end else begin
         win_index = {3'b000, p[6:0]};
      end
   endfunction

   // Two-flop synchronisers for every pin input
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta <= mmc_pkg::PINS_RESET;   // Undriven select reads deselected
         pin      <= mmc_pkg::PINS_RESET;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         pin_meta <= '{sel_n: module_select_n, rst_n: module_reset_n,
                       lp: low_power_request, scl: scl_in, sda: sda_in};
         pin      <= pin_meta;
         scl_prev <= pin.scl;
         sda_prev <= pin.sda;
      end
   end

   // Presence is a plain ground on the module side
   assign module_present_n = 1'b0;
   // Open-drain pins only ever pull low; enable decides
   assign sda_out         = 1'b0;
   assign interrupt_out_n = 1'b0;
   assign sda_oe_n        = ~drive_low;
   assign interrupt_oe_n  = ~irq;
   assign hresp           = 1'b0;
   assign hreadyout       = ~rd_pend;

   // Byte returned to the host; status byte carries live data-not-ready
   always_comb begin
      rd_byte = mem[win_index(ptr, mem[mmc_pkg::PAGE_SEL_BYTE][1:0])];
      if (ptr == 8'(mmc_pkg::STATUS_BYTE)) begin
         rd_byte[mmc_pkg::DNR_BIT] = init_active | soft_reset;
      end
   end

   // 2-wire slave: next state
   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      scl_rise       = pin.scl & ~scl_prev;
      scl_fall       = ~pin.scl & scl_prev;
      start_c        = pin.scl & scl_prev & sda_prev & ~pin.sda;
      stop_c         = pin.scl & scl_prev & ~sda_prev & pin.sda;
      next_state     = state;
      next_shreg     = shreg;
      next_bit_cnt   = bit_cnt;
      next_first     = first;
      next_got_ptr   = got_ptr;
      next_rd_mode   = rd_mode;
      next_ack_ok    = ack_ok;
      next_drive_low = drive_low;
      next_ptr       = ptr;
      i2c_wr         = 1'b0;
      i2c_rd         = 1'b0;
      i2c_idx        = win_index(ptr, mem[mmc_pkg::PAGE_SEL_BYTE][1:0]);
      if (pin.sel_n || soft_reset) begin
         // Deselected or in reset: no answer, line released, machine parked
         next_state     = mmc_pkg::I2C_IDLE;
         next_drive_low = 1'b0;
      end else if (start_c) begin
         // Start or repeated start while selected
         next_state     = mmc_pkg::I2C_RX;
         next_bit_cnt   = 4'h0;
         next_first     = 1'b1;
         next_drive_low = 1'b0;
      end else if (stop_c) begin
         next_state     = mmc_pkg::I2C_IDLE;
         next_drive_low = 1'b0;
      end else begin
         case (state)
            mmc_pkg::I2C_IDLE: begin
               next_drive_low = 1'b0;
            end
            mmc_pkg::I2C_RX: begin
               if (scl_rise && bit_cnt < 4'h8) begin
                  next_shreg   = {shreg[6:0], pin.sda};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  if (first) begin
                     // Only our address is acknowledged
                     if (shreg[7:1] == mmc_pkg::DEV_ADDR) begin
                        next_rd_mode   = shreg[0];
                        next_got_ptr   = 1'b0;
                        next_first     = 1'b0;
                        next_drive_low = 1'b1;
                        next_state     = mmc_pkg::I2C_ACK_OUT;
                     end else begin
                        next_state = mmc_pkg::I2C_IDLE;
                     end
                  end else begin
                     if (!got_ptr) begin
                        next_ptr     = shreg;
                        next_got_ptr = 1'b1;
                     end else begin
                        // Host writes reach control bytes and upper pages only
                        i2c_wr   = ptr >= 8'(mmc_pkg::CTRL_FIRST);
                        next_ptr = ptr + 8'h01;
                     end
                     next_drive_low = 1'b1;
                     next_state     = mmc_pkg::I2C_ACK_OUT;
                  end
               end
            end
            mmc_pkg::I2C_ACK_OUT: begin
               if (scl_fall) begin
                  next_bit_cnt = 4'h0;
                  if (rd_mode) begin
                     // Load the first read byte and put its MSB out
                     i2c_rd         = 1'b1;
                     next_shreg     = rd_byte;
                     next_ptr       = ptr + 8'h01;
                     next_drive_low = ~rd_byte[7];
                     next_state     = mmc_pkg::I2C_TX;
                  end else begin
                     next_drive_low = 1'b0;
                     next_state     = mmc_pkg::I2C_RX;
                  end
               end
            end
            mmc_pkg::I2C_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == 4'h7) begin
                     next_drive_low = 1'b0;
                     next_state     = mmc_pkg::I2C_ACK_IN;
                  end else begin
                     next_shreg     = {shreg[6:0], 1'b0};
                     next_drive_low = ~shreg[6];
                     next_bit_cnt   = bit_cnt + 4'h1;
                  end
               end
            end
            mmc_pkg::I2C_ACK_IN: begin
               if (scl_rise) begin
                  next_ack_ok = ~pin.sda;
               end else if (scl_fall) begin
                  if (ack_ok) begin
                     i2c_rd         = 1'b1;
                     next_shreg     = rd_byte;
                     next_ptr       = ptr + 8'h01;
                     next_drive_low = ~rd_byte[7];
                     next_bit_cnt   = 4'h0;
                     next_state     = mmc_pkg::I2C_TX;
                  end else begin
                     next_state = mmc_pkg::I2C_IDLE;
                  end
               end
            end
            default: begin
               next_state     = mmc_pkg::I2C_IDLE;
               next_drive_low = 1'b0;
            end
         endcase
      end
   end

   // 2-wire slave: registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state     <= mmc_pkg::I2C_IDLE;
         shreg     <= 8'h00;
         bit_cnt   <= 4'h0;
         first     <= 1'b1;
         got_ptr   <= 1'b0;
         rd_mode   <= 1'b0;
         ack_ok    <= 1'b0;
         drive_low <= 1'b0;
         ptr       <= 8'h00;
      end else begin
         state     <= next_state;
         shreg     <= next_shreg;
         bit_cnt   <= next_bit_cnt;
         first     <= next_first;
         got_ptr   <= next_got_ptr;
         rd_mode   <= next_rd_mode;
         ack_ok    <= next_ack_ok;
         drive_low <= next_drive_low;
         ptr       <= next_ptr;
      end
   end

   // Reset pin timing and the init interval
   always_comb begin
      next_low_cnt     = low_cnt;
      next_init_active = init_active;
      next_init_cnt    = init_cnt;
      done_set         = 1'b0;
      // Pulse counts as a reset only once it outlasts the minimum
      soft_reset = ~pin.rst_n && (low_cnt >= 10'(mmc_pkg::RST_MIN_CYC));
      if (!pin.rst_n) begin
         if (low_cnt < 10'(mmc_pkg::RST_MIN_CYC)) begin
            next_low_cnt = low_cnt + 10'h001;
         end
         next_init_active = soft_reset | init_active;
      end else begin
         next_low_cnt = 10'h000;
         if (low_cnt >= 10'(mmc_pkg::RST_MIN_CYC)) begin
            // Interval counted from the release edge
            next_init_active = 1'b1;
            next_init_cnt    = 32'h0000_0000;
         end else if (init_active) begin
            // Functional within the init bound of the release
            if (init_cnt >= INIT_CYCLES - 1) begin
               next_init_active = 1'b0;
               done_set         = 1'b1;
            end else begin
               next_init_cnt = init_cnt + 32'h0000_0001;
            end
         end
      end
      // Completion latch; set wins over the clear-on-read
      next_done_flag = done_flag;
      if (soft_reset) begin
         next_done_flag = 1'b0;
      end else if (i2c_rd && i2c_idx == 10'(mmc_pkg::STATUS_BYTE)) begin
         next_done_flag = 1'b0;
      end
      if (done_set) begin
         next_done_flag = 1'b1;
      end
   end

   // Power-up starts an init interval with no reset pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt     <= 10'h000;
         init_active <= 1'b1;
         init_cnt    <= 32'h0000_0000;
         done_flag   <= 1'b0;
      end else begin
         low_cnt     <= next_low_cnt;
         init_active <= next_init_active;
         init_cnt    <= next_init_cnt;
         done_flag   <= next_done_flag;
      end
   end

   // Management memory: reset restore, host writes, flag clear and set
   always_comb begin
      next_mem = mem;
      if (soft_reset) begin
         for (int i = mmc_pkg::CTRL_FIRST; i <= mmc_pkg::PAGE_SEL_BYTE; i++) begin
            next_mem[i] = mmc_pkg::MEM_RESET;   // Page select back to 0 too
         end
      end
      if (i2c_wr) begin
         next_mem[i2c_idx] = shreg;
      end
      // Reading a flag byte clears it; a same-cycle event still lands
      if (i2c_rd && i2c_idx >= 10'(mmc_pkg::FLAG_FIRST)
                 && i2c_idx <= 10'(mmc_pkg::FLAG_LAST)) begin
         next_mem[i2c_idx] = 8'h00;
      end
      if (bus_wr_mem) begin
         next_mem[mem_idx] = hwdata[7:0];
      end
      if (bus_flag_ev) begin
         next_mem[hwdata[mmc_pkg::FE_BYTE_LSB +: 8]] =
            next_mem[hwdata[mmc_pkg::FE_BYTE_LSB +: 8]] | hwdata[mmc_pkg::FE_BITS_LSB +: 8];
      end
      // Interrupt on any latched flag or pending completion
      flag_any = 1'b0;
      for (int i = mmc_pkg::FLAG_FIRST; i <= mmc_pkg::FLAG_LAST; i++) begin
         flag_any = flag_any | (|next_mem[i]);
      end
      // Release follows the clearing read by one cycle
      next_irq = flag_any | next_done_flag;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < mmc_pkg::MEM_BYTES; i++) begin
            mem[i] <= mmc_pkg::MEM_RESET;
         end
         irq <= 1'b0;
      end else begin
         mem <= next_mem;
         irq <= next_irq;
      end
   end

   // Power level follows the synchronised request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_power_state <= 1'b0;
      end else begin
         low_power_state <= pin.lp;
      end
   end

   // AHB slave: writes in the data phase, reads take one wait state
   always_comb begin
      next_aph     = mmc_pkg::mmc_ahb_s'(0);
      next_rd_pend = 1'b0;
      next_hrdata  = hrdata;
      next_mem_idx = mem_idx;
      bus_wr_mem   = 1'b0;
      bus_flag_ev  = 1'b0;
      selected_data = (mem_idx < 10'(mmc_pkg::MEM_BYTES)) ? mem[mem_idx] : 8'h00;
      // New address phase taken only while the bus is ready
      if (hsel && htrans[1] && hready) begin
         next_aph     = '{valid: 1'b1, write: hwrite, addr: haddr[7:0]};
         next_rd_pend = ~hwrite;
      end
      if (aph.valid && aph.write) begin
         case (aph.addr)
            mmc_pkg::REG_FLAG_EVENT: begin
               bus_flag_ev = (hwdata[mmc_pkg::FE_BYTE_LSB +: 8] >= 8'(mmc_pkg::FLAG_FIRST))
                          && (hwdata[mmc_pkg::FE_BYTE_LSB +: 8] <= 8'(mmc_pkg::FLAG_LAST));
            end
            mmc_pkg::REG_MEM_ADDR: begin
               next_mem_idx = hwdata[9:0];
            end
            mmc_pkg::REG_MEM_DATA: begin
               bus_wr_mem = mem_idx < 10'(mmc_pkg::MEM_BYTES);
            end
            default: begin
               // Unmapped or read-only: write ignored
            end
         endcase
      end
      if (rd_pend) begin
         // Data phase of a read: hold ready low one cycle and capture
         next_aph    = aph;
         next_hrdata = 32'h0000_0000;
         case (aph.addr)
            mmc_pkg::REG_STATUS: begin
               next_hrdata[mmc_pkg::ST_SELECTED] = ~pin.sel_n;
               next_hrdata[mmc_pkg::ST_INIT]     = init_active;
               next_hrdata[mmc_pkg::ST_IRQ]      = irq;
               next_hrdata[mmc_pkg::ST_LOWPOWER] = low_power_state;
               next_hrdata[mmc_pkg::ST_DONE]     = done_flag;
            end
            mmc_pkg::REG_MEM_ADDR: begin
               next_hrdata[9:0] = mem_idx;
            end
            mmc_pkg::REG_MEM_DATA: begin
               next_hrdata[7:0] = selected_data;
            end
            default: begin
               next_hrdata = 32'h0000_0000;
            end
         endcase
         next_aph.valid = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph     <= mmc_pkg::mmc_ahb_s'(0);
         rd_pend <= 1'b0;
         hrdata  <= 32'h0000_0000;
         mem_idx <= 10'h000;
      end else begin
         aph     <= next_aph;
         rd_pend <= next_rd_pend;
         hrdata  <= next_hrdata;
         mem_idx <= next_mem_idx;
      end
   end

endmodule

// >>> mmc_props_properties.sv
// Checker on the pins of the management pin block.
// Assumes flag bytes are clear whenever the module reset pin is pulsed.
`timescale 1ns/1ns
module mmc_props #(parameter int unsigned INIT_CYCLES = 200) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic module_select_n,
   input wire logic module_reset_n,
   input wire logic low_power_request,
   input wire logic sda_oe_n,
   input wire logic interrupt_out_n,
   input wire logic interrupt_oe_n,
   input wire logic module_present_n,
   input wire logic low_power_state
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [9:0]  low_cnt;       // Raw cycles with reset pin low
   logic [9:0]  next_low_cnt;
   logic [31:0] since;         // Cycles since power-up or valid pin reset
   logic [31:0] next_since;
   // Both saturate so a long run never wraps into a checked window
   always_comb begin
      next_low_cnt = module_reset_n ? 10'h000 : low_cnt + {9'h000, low_cnt != 10'h3ff};
      next_since = (!module_reset_n && low_cnt > 10'h1f2) ? 32'h0
                   : since + {31'h0, since < INIT_CYCLES + 16};
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt <= 10'h000;
         since   <= 32'h0;
      end else begin
         low_cnt <= next_low_cnt;
         since   <= next_since;
      end
   end
   present_tied_a: assert property (!module_present_n)
      else $error("presence not low");
   irq_low_only_a: assert property (!interrupt_out_n)
      else $error("interrupt driven high");
   deselect_quiet_a: assert property (module_select_n [*8] |-> sda_oe_n)
      else $error("data pulled while deselected");
   lp_enter_a: assert property (low_power_request [*5] |-> low_power_state)
      else $error("low power not entered");
   lp_leave_a: assert property (!low_power_request [*5] |-> !low_power_state)
      else $error("low power not left");
   reset_idle_a: assert property (low_cnt > 10'h1fe |-> sda_oe_n)
      else $error("slave active in reset");
   init_quiet_a: assert property (since == INIT_CYCLES - 1 |-> interrupt_oe_n)
      else $error("completion too early");
   init_done_a: assert property (since == INIT_CYCLES + 12 |-> !interrupt_oe_n)
      else $error("completion missing");
endmodule
bind mmc_mgmt_pins mmc_props #(.INIT_CYCLES(INIT_CYCLES)) i_props (.*);

// >>> mmc_host.sv
// 2-wire host with its own select line per module; 125 ns per bit.
// Assumes the bench wires the data line with a pull-up and returns it.
`timescale 1ns/1ns
module mmc_host (
   output logic      scl,
   output logic      sda_h,
   output logic      module_select_n,
   input  wire logic sda_w
);
   initial begin  // Idle bus, clock still, deselected
      scl = 1'b1;
      sda_h = 1'b1;
      module_select_n = 1'b1;
   end
   task sel(input logic b);  // Only the addressed module selected
      module_select_n = b;
   endtask
   // One bit: drive (1 releases) while low, sample mid-high
   task bx(input logic b, output logic s);
      sda_h = b;
      #31 scl = 1'b1;
      #31 s = sda_w;
      #32 scl = 1'b0;
      #31;
   endtask
   task cond(input logic a, input logic b);  // Start (1,0) or stop (0,1)
      sda_h = a;
      #31 scl = 1'b1;
      #31 sda_h = b;
      #32 scl = b;
      #31;
   endtask
   task by(input logic [7:0] w, output logic [7:0] r, output logic n);
      for (int i = 7; i >= 0; i--) bx(w[i], r[i]);
      bx(1'b1, n);  // Ninth bit; a read ends with not-acknowledge
   endtask
   task xfer(input logic [7:0] dev, input logic [7:0] off, input logic rd,
             inout logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic [2:0] n;
      cond(1'b1, 1'b0);
      by(dev, r, n[0]);
      by(off, r, n[1]);
      if (rd) begin
         cond(1'b1, 1'b0);
         by(dev | 8'h01, r, n[2]);
         by(8'hff, d, r[0]);
      end else
         by(d, r, n[2]);
      cond(1'b0, 1'b1);
      ok = (n === 3'b000);
   endtask
endmodule

// >>> tb_top.sv
// Bench: bus master, 2-wire host, pin drivers and a memory model.
// Assumes one bus slave, so its ready output is fed back as hready.
`timescale 1ns/1ns
module tb_top;
   localparam int unsigned INIT = 3000;  // Short init interval
   logic        hclk, hresetn, hsel, hwrite, module_reset_n, low_power_request;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic        hreadyout, hresp, scl, sda_h, sda_w, sda_out, sda_oe_n, sel_n, ok;
   logic        int_out, int_oe_n, irq_w, present_n, lp_state;
   logic [7:0]  d8;
   int          errors = 0, tests_run = 0, cyc = 0, pg, off;
   int          mem [640];  // Model memory
   assign sda_w = sda_h & (sda_oe_n | sda_out);  // Pull-up lines
   assign irq_w = int_oe_n | int_out;
   mmc_mgmt_pins #(.INIT_CYCLES(INIT)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .module_select_n(sel_n), .module_reset_n(module_reset_n), .scl_in(scl),
      .low_power_request(low_power_request), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .interrupt_out_n(int_out), .interrupt_oe_n(int_oe_n),
      .module_present_n(present_n), .low_power_state(lp_state));
   mmc_host i_host (.scl(scl), .sda_h(sda_h), .module_select_n(sel_n), .sda_w(sda_w));
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   always @(posedge hclk) begin  // Watchdog
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         print_verdict;
      end
   end
   task print_verdict;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task rdy_edge;  // Edge where ready is sampled high
      @(negedge hclk);
      while (hreadyout !== 1'b1) @(negedge hclk);
      @(posedge hclk);
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy_edge;
      htrans <= 2'h0;
      hwdata <= d;
      rdy_edge;
      rd = hrdata;
   endtask
   function automatic int idx(int o);  // Upper offsets via page byte
      return o < 128 ? o : o + 128 * (mem[127] & 3);
   endfunction
   task wr2(input logic [7:0] dev, input int o, input int v, input logic e);
      d8 = v[7:0];
      i_host.xfer(dev, o[7:0], 1'b0, d8, ok);
      chk("write ack", e, ok);
      if (e && o > 85) mem[idx(o)] = v & 255;  // Status area read-only
   endtask
   task rd2(input int o);
      i_host.xfer(8'ha0, o[7:0], 1'b1, d8, ok);
      chk("read ack", 1, ok);
      chk("read byte", mem[idx(o)], d8);
      if (o > 2 && o < 22) mem[o] = 0;  // Flags clear on read
   endtask
   task irq(input logic e);
      repeat (20) @(posedge hclk);
      chk("irq line", e, irq_w);
   endtask
   task pin_reset(input int n);
      @(posedge hclk);
      module_reset_n <= 1'b0;
      repeat (n) @(posedge hclk);
      module_reset_n <= 1'b1;
      repeat (8) @(posedge hclk);
      ahb(1'b0, mmc_pkg::REG_STATUS, 0);
   endtask
   initial begin
      rd = $urandom(32'he93fb768);
      hresetn = 1'b0;
      hsel = 1'b1;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      module_reset_n = 1'b1;
      low_power_request = 1'b0;
      mem[2] = 1;  // Data not ready during init
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      i_host.sel(1'b0);
      rd2(2);
      ahb(1'b0, mmc_pkg::REG_STATUS, 0);
      chk("init", 1, rd[mmc_pkg::ST_INIT]);
      repeat (INIT) @(posedge hclk);
      mem[2] = 0;
      irq(1'b0);
      rd2(2);
      irq(1'b1);
      i_host.sel(1'b1);
      wr2(8'ha0, 86, 7, 1'b0);
      i_host.sel(1'b0);
      wr2(8'ha0, 86, $urandom, 1'b1);
      wr2(8'ha4, 86, 9, 1'b0);
      wr2(8'ha0, 10, 8'h5a, 1'b1);
      rd2(86);
      rd2(10);
      pg = $urandom_range(3);
      off = 128 + $urandom_range(127);
      wr2(8'ha0, 127, pg, 1'b1);
      wr2(8'ha0, off, $urandom, 1'b1);
      ahb(1'b1, mmc_pkg::REG_MEM_ADDR, idx(off));
      ahb(1'b0, mmc_pkg::REG_MEM_DATA, 0);
      chk("paged", mem[idx(off)], rd);
      ahb(1'b1, mmc_pkg::REG_MEM_DATA, 8'h3c);
      mem[idx(off)] = 8'h3c;
      rd2(off);
      off = 3 + $urandom_range(18);
      d8 = 8'h01 << $urandom_range(7);
      ahb(1'b1, mmc_pkg::REG_FLAG_EVENT, {16'h0, off[7:0], d8});
      mem[off] = d8;
      irq(1'b0);
      rd2(off);
      irq(1'b1);
      low_power_request <= 1'b1;
      repeat (5) @(posedge hclk);
      chk("low power", 1, lp_state);
      chk("present", 0, present_n);
      pin_reset(400);
      chk("short", 0, rd[mmc_pkg::ST_INIT]);
      chk("status lp", 1, rd[mmc_pkg::ST_LOWPOWER]);
      chk("status sel", 1, {hresp, rd[mmc_pkg::ST_SELECTED]});
      pin_reset(600);
      for (int i = 86; i < 128; i++) mem[i] = 0;
      chk("init", 1, rd[mmc_pkg::ST_INIT]);
      rd2(86);
      repeat (INIT) @(posedge hclk);
      irq(1'b0);
      print_verdict;
   end
endmodule
